// ### hdl/adc_backend_pkg.sv
// Purpose : shared constants of the mono adc back end
// Assumes : page 0 registers, 7-bit register index
// Notes   : divider field 0 stands for 128, osr 0 for 256

package adc_backend_pkg;

  // ---------------------------------------------------------------
  // register indexes
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_PAGE       = 7'h00;
  localparam logic [6:0] ADDR_DIV_FIRST  = 7'h12;
  localparam logic [6:0] ADDR_DIV_SECOND = 7'h13;
  localparam logic [6:0] ADDR_OSR        = 7'h14;
  localparam logic [6:0] ADDR_IFACE      = 7'h1B;
  localparam logic [6:0] ADDR_PIN_ONE    = 7'h33;
  localparam logic [6:0] ADDR_ADC_POWER  = 7'h51;
  localparam logic [6:0] ADDR_DC_CONFIG  = 7'h66;
  localparam logic [6:0] ADDR_DC_LATCH   = 7'h67;
  localparam logic [6:0] ADDR_DC_READ_HI = 7'h68;
  localparam logic [6:0] ADDR_DC_READ_MD = 7'h69;
  localparam logic [6:0] ADDR_DC_READ_LO = 7'h6A;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int         DIV_POWER_BIT   = 7;
  localparam int         ADC_POWER_BIT   = 7;
  localparam int         PIN_FUNC_LSB    = 2;
  localparam int         PIN_FUNC_MSB    = 5;
  localparam logic [3:0] PIN_FUNC_MODCLK = 4'hA;
  localparam int         WL_LSB          = 4;
  localparam int         WL_MSB          = 5;
  localparam int         DC_ENABLE_BIT   = 7;
  localparam int         DC_IIR_BIT      = 5;
  localparam int         DC_LEN_MSB      = 4;
  localparam int         DC_LATCH_BIT    = 6;
  localparam int         DC_PERIODIC_BIT = 5;
  localparam logic [4:0] DC_LEN_MIN      = 5'h01;
  localparam logic [4:0] DC_LEN_MAX      = 5'h14;

  // ---------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------
  localparam logic [7:0] DIV_RESET   = 8'h01;
  localparam logic [7:0] OSR_RESET   = 8'h80;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam int         ADC_WORD_W  = 32;
  localparam int         DC_RESULT_W = 24;
  localparam int         DC_FRAC_W   = 22;

  typedef enum logic [1:0] {
    WL_16 = 2'b00,
    WL_20 = 2'b01,
    WL_24 = 2'b10,
    WL_32 = 2'b11
  } word_len_t;

  // round to nearest at the chosen length, saturating on overflow
  function automatic logic [31:0] roundWord(input logic [31:0] w,
                                            input word_len_t   wl);
    logic [31:0] half;
    logic [31:0] mask;
    logic [31:0] sum;
    half = 32'h0000_0000;
    mask = 32'hFFFF_FFFF;
    unique case (wl)
      WL_16: begin half = 32'h0000_8000; mask = 32'hFFFF_0000; end
      WL_20: begin half = 32'h0000_0800; mask = 32'hFFFF_F000; end
      WL_24: begin half = 32'h0000_0080; mask = 32'hFFFF_FF00; end
      WL_32: begin half = 32'h0000_0000; mask = 32'hFFFF_FFFF; end
    endcase
    sum = w + half;
    if (!w[31] && sum[31])
      roundWord = 32'h7FFF_FFFF & mask;
    else
      roundWord = sum & mask;
  endfunction

endpackage

// ### hdl/tick_divider.sv
// Purpose : counts advance pulses and emits a tick every divisor
// Assumes : divisor 1 to 2^WIDTH, held stable while running
// Notes   : count is also used by the caller to shape a clock
`timescale 1ns/1ps

module tick_divider #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic             run,
  input  wire logic             advance,
  input  wire logic [WIDTH:0]   divisor,
  output logic                  tick,
  output logic      [WIDTH-1:0] count
);

  if (WIDTH < 2 || WIDTH > 16)
  begin : g_check
    $error("tick_divider WIDTH must be 2 to 16");
  end

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH:0]   lastCount;
  logic             atLast;

  assign lastCount = divisor - {{WIDTH{1'b0}}, 1'b1};
  assign atLast    = ({1'b0, count_q} >= lastCount);
  assign tick      = run && advance && atLast;
  assign count     = count_q;
  assign count_d   = !run    ? '0 :
                     !advance ? count_q :
                     atLast   ? '0 : count_q + 1'b1;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      count_q <= '0;
    else if (clkEn)
      count_q <= count_d;
  end

endmodule // tick_divider

// ### hdl/adc_backend.sv
// Purpose : mono adc back end with microphone port and dc measure
// Assumes : ref_clk is the converter input clock
// Notes   : register reads answer one cycle after the strobe
`timescale 1ns/1ps

module adc_backend (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             clkEn,
  input  wire logic                             regWrEn,
  input  wire logic                             regRdEn,
  input  wire logic [6:0]                       regAddr,
  input  wire logic [7:0]                       regWrData,
  output logic      [7:0]                       regRdData,
  input  wire logic                             micMode,
  input  wire logic                             analogModBit,
  input  wire logic                             serialDataIn,
  output logic                                  pinOneOut,
  output logic                                  pinOneOeN,
  output logic [adc_backend_pkg::ADC_WORD_W-1:0] leftWord,
  output logic [adc_backend_pkg::ADC_WORD_W-1:0] rightWord,
  output logic                                  wordValid
);
  import adc_backend_pkg::*;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0]  page_q;
  logic [7:0]  divFirst_q;
  logic [7:0]  divSecond_q;
  logic [7:0]  osr_q;
  logic [7:0]  iface_q;
  logic [7:0]  pinOne_q;
  logic [7:0]  adcPower_q;
  logic [7:0]  dcConfig_q;
  logic [7:0]  dcLatch_q;
  logic [7:0]  regRdData_q;
  logic [DC_RESULT_W-1:0] readBack_q;
  logic [DC_RESULT_W-1:0] dcResult_q;

  wire         pageZero  = (page_q == REG_RESET);
  wire         wrPage0   = regWrEn && pageZero;
  wire         wrLatch   = wrPage0 && (regAddr == ADDR_DC_LATCH);
  wire         latchRise = wrLatch && regWrData[DC_LATCH_BIT] &&
                           !dcLatch_q[DC_LATCH_BIT];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      page_q      <= REG_RESET;
      divFirst_q  <= DIV_RESET;
      divSecond_q <= DIV_RESET;
      osr_q       <= OSR_RESET;
      iface_q     <= REG_RESET;
      pinOne_q    <= REG_RESET;
      adcPower_q  <= REG_RESET;
      dcConfig_q  <= REG_RESET;
      dcLatch_q   <= REG_RESET;
    end
    else if (clkEn && regWrEn)
    begin
      if (regAddr == ADDR_PAGE)
        page_q <= regWrData;
      else if (pageZero)
      begin
        unique case (regAddr)
          ADDR_DIV_FIRST:  divFirst_q  <= regWrData;
          ADDR_DIV_SECOND: divSecond_q <= regWrData;
          ADDR_OSR:        osr_q       <= regWrData;
          ADDR_IFACE:      iface_q     <= regWrData;
          ADDR_PIN_ONE:    pinOne_q    <= regWrData;
          ADDR_ADC_POWER:  adcPower_q  <= regWrData;
          ADDR_DC_CONFIG:  dcConfig_q  <= regWrData;
          ADDR_DC_LATCH:   dcLatch_q   <= regWrData;
          default:         ;
        endcase
      end
    end
  end

  // snapshot only on the 0 to 1 edge so bytes stay coherent
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      readBack_q <= '0;
    else if (clkEn && latchRise)
      readBack_q <= dcResult_q;
  end

  logic [7:0] rdMux;
  always_comb
  begin
    rdMux = 8'h00;
    if (regAddr == ADDR_PAGE)
      rdMux = page_q;
    else if (pageZero)
    begin
      unique case (regAddr)
        ADDR_DIV_FIRST:  rdMux = divFirst_q;
        ADDR_DIV_SECOND: rdMux = divSecond_q;
        ADDR_OSR:        rdMux = osr_q;
        ADDR_IFACE:      rdMux = iface_q;
        ADDR_PIN_ONE:    rdMux = pinOne_q;
        ADDR_ADC_POWER:  rdMux = adcPower_q;
        ADDR_DC_CONFIG:  rdMux = dcConfig_q;
        ADDR_DC_LATCH:   rdMux = dcLatch_q;
        ADDR_DC_READ_HI: rdMux = readBack_q[23:16];
        ADDR_DC_READ_MD: rdMux = readBack_q[15:8];
        ADDR_DC_READ_LO: rdMux = readBack_q[7:0];
        default:         rdMux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      regRdData_q <= 8'h00;
    else if (clkEn && regRdEn)
      regRdData_q <= rdMux;
  end
  assign regRdData = regRdData_q;

  // ---------------------------------------------------------------
  // clock dividers
  // ---------------------------------------------------------------
  wire [8:0] firstDiv  = (divFirst_q[6:0] == 7'h00) ? 9'h080 :
                         {2'b00, divFirst_q[6:0]};
  wire [8:0] secondDiv = (divSecond_q[6:0] == 7'h00) ? 9'h080 :
                         {2'b00, divSecond_q[6:0]};
  wire [9:0] osrDiv    = (osr_q == 8'h00) ? 10'h100 : {2'b00, osr_q};
  wire       firstRun  = divFirst_q[DIV_POWER_BIT];
  wire       secondRun = firstRun && divSecond_q[DIV_POWER_BIT];

  logic       firstTick;
  logic       modTick;
  logic       sampleTick;
  logic [7:0] secondCount;

  // input clock / first / second / osr gives the sample rate
  tick_divider #(.WIDTH(8)) u_div_first (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .run     (firstRun),
    .advance (1'b1),
    .divisor (firstDiv),
    .tick    (firstTick),
    .count   ()
  );

  tick_divider #(.WIDTH(8)) u_div_second (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .run     (secondRun),
    .advance (firstTick),
    .divisor (secondDiv),
    .tick    (modTick),
    .count   (secondCount)
  );

  tick_divider #(.WIDTH(9)) u_div_osr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .run     (secondRun),
    .advance (modTick),
    .divisor (osrDiv),
    .tick    (sampleTick),
    .count   ()
  );

  // modulator clock: high in the first half of the second divider
  wire [8:0] halfSecond = (secondDiv + 9'h001) >> 1;
  wire       modClkLvl  = secondRun && ({1'b0, secondCount} < halfSecond);

  // ---------------------------------------------------------------
  // general pin one and microphone input
  // ---------------------------------------------------------------
  wire  pinModClk = (pinOne_q[PIN_FUNC_MSB:PIN_FUNC_LSB] == PIN_FUNC_MODCLK);
  logic pinOneOut_q;
  logic pinOneOeN_q;
  logic dinMeta_q;
  logic dinSync_q;
  logic modBit_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pinOneOut_q <= 1'b0;
      pinOneOeN_q <= 1'b1;
      dinMeta_q   <= 1'b0;
      dinSync_q   <= 1'b0;
      modBit_q    <= 1'b0;
    end
    else if (clkEn)
    begin
      pinOneOut_q <= pinModClk && modClkLvl;
      pinOneOeN_q <= !pinModClk;
      dinMeta_q   <= serialDataIn;
      dinSync_q   <= dinMeta_q;
      // latch the steady bit as the modulator clock rises
      if (modTick)
        modBit_q <= micMode ? dinSync_q : analogModBit;
    end
  end
  assign pinOneOut = pinOneOut_q;
  assign pinOneOeN = pinOneOeN_q;

  // one delayed tick so the freshly latched bit is used
  logic modTickD_q;
  logic sampleTickD_q;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      modTickD_q    <= 1'b0;
      sampleTickD_q <= 1'b0;
    end
    else if (clkEn)
    begin
      modTickD_q    <= modTick;
      sampleTickD_q <= sampleTick;
    end
  end

  // ---------------------------------------------------------------
  // decimation and serial port words
  // ---------------------------------------------------------------
  logic signed [9:0] decAcc_q;
  logic [31:0]       leftWord_q;
  logic [31:0]       rightWord_q;
  logic              wordValid_q;

  wire signed [9:0] bitStep   = modBit_q ? 10'sh001 : -10'sh001;
  wire signed [9:0] decSum    = decAcc_q + bitStep;
  wire [31:0]       rawWord   = {decSum, {DC_FRAC_W{1'b0}}};
  wire [31:0]       slotWord  =
    roundWord(rawWord, word_len_t'(iface_q[WL_MSB:WL_LSB]));
  wire              audioOn   = adcPower_q[ADC_POWER_BIT] &&
                                !dcConfig_q[DC_ENABLE_BIT];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      decAcc_q <= '0;
    else if (clkEn && modTickD_q)
      decAcc_q <= sampleTickD_q ? 10'sh000 : decSum;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      leftWord_q  <= '0;
      rightWord_q <= '0;
      wordValid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      wordValid_q <= sampleTickD_q && audioOn;
      if (sampleTickD_q && audioOn)
      begin
        leftWord_q  <= slotWord;
        rightWord_q <= slotWord;
      end
    end
  end
  assign leftWord  = leftWord_q;
  assign rightWord = rightWord_q;
  assign wordValid = wordValid_q;

  // ---------------------------------------------------------------
  // dc measurement
  // ---------------------------------------------------------------
  logic signed [21:0] avgAcc_q;
  logic [20:0]        avgCnt_q;
  logic signed [31:0] iirY_q;
  logic [31:0]        periodCnt_q;

  wire        dcOn      = dcConfig_q[DC_ENABLE_BIT];
  wire        useIir    = dcConfig_q[DC_IIR_BIT];
  wire [4:0]  lenRaw    = dcConfig_q[DC_LEN_MSB:0];
  wire [4:0]  dcLen     = (lenRaw < DC_LEN_MIN) ? DC_LEN_MIN :
                          (lenRaw > DC_LEN_MAX) ? DC_LEN_MAX : lenRaw;
  wire        periodic  = dcLatch_q[DC_PERIODIC_BIT];
  wire [4:0]  resetExp  = dcLatch_q[DC_LEN_MSB:0];
  wire [31:0] periodEnd = (32'h0000_0001 << resetExp) - 32'h0000_0001;
  wire [20:0] avgEnd    = 21'((22'h00_0001 << dcLen) - 22'h00_0001);
  // compare at or above so a lowered exponent does not let it run away
  wire        periodHit = periodic && (periodCnt_q >= periodEnd);

  wire signed [21:0] avgSum  = avgAcc_q + 22'(bitStep);
  wire signed [31:0] avgWide = 32'(avgSum) <<< (5'd22 - dcLen);
  wire signed [31:0] unitX   = modBit_q ? 32'sh0040_0000 :
                                          -32'sh0040_0000;
  wire signed [31:0] iirNext = iirY_q + ((unitX - iirY_q) >>> dcLen);
  wire               avgDone = (avgCnt_q == avgEnd);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      avgAcc_q    <= '0;
      avgCnt_q    <= '0;
      iirY_q      <= '0;
      periodCnt_q <= '0;
      dcResult_q  <= '0;
    end
    else if (clkEn && !dcOn)
    begin
      avgAcc_q    <= '0;
      avgCnt_q    <= '0;
      iirY_q      <= '0;
      periodCnt_q <= '0;
    end
    else if (clkEn && modTickD_q)
    begin
      periodCnt_q <= periodHit ? 32'h0000_0000 : periodCnt_q + 1'b1;
      if (useIir)
      begin
        iirY_q     <= iirNext;
        dcResult_q <= iirNext[DC_RESULT_W-1:0];
      end
      else if (periodHit)
      begin
        avgAcc_q <= '0;
        avgCnt_q <= '0;
      end
      else if (avgDone)
      begin
        avgAcc_q   <= '0;
        avgCnt_q   <= '0;
        dcResult_q <= avgWide[DC_RESULT_W-1:0];
      end
      else
      begin
        avgAcc_q <= avgSum;
        avgCnt_q <= avgCnt_q + 1'b1;
      end
    end
  end

endmodule // adc_backend

// ### dv/adc_backend_sva.sv
// Purpose : port checks of the mono adc back end
// Assumes : host writes are shadowed here to know the settings
// Notes   : the bench keeps clkEn high
`timescale 1ns/1ps

module adc_backend_sva (
  input wire logic                                 ref_clk,
  input wire logic                                 rst,
  input wire logic                                 clkEn,
  input wire logic                                 regWrEn,
  input wire logic                                 regRdEn,
  input wire logic [6:0]                           regAddr,
  input wire logic [7:0]                           regWrData,
  input wire logic [7:0]                           regRdData,
  input wire logic                                 pinOneOut,
  input wire logic                                 pinOneOeN,
  input wire logic [adc_backend_pkg::ADC_WORD_W-1:0] leftWord,
  input wire logic [adc_backend_pkg::ADC_WORD_W-1:0] rightWord,
  input wire logic                                 wordValid
);
  import adc_backend_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------
  // shadow of the host settings
  // ------------------------------------------
  logic [7:0]  page_q, divF_q, divS_q, iface_q, pinCfg_q, power_q, dcCfg_q;
  logic [2:0]  off_q;
  logic [15:0] gap_q;
  logic        armed_q, pinPrev_q;
  wire logic   wr, mapped, refused, pinSel, wordsOn, rise, divWr;
  wire logic [15:0] period;
  wire logic [31:0] lowMask;
  assign wr = regWrEn && clkEn && (page_q == 8'h00 || regAddr == ADDR_PAGE);
  assign mapped = regAddr inside {ADDR_PAGE, ADDR_DIV_FIRST, ADDR_DIV_SECOND,
    ADDR_OSR, ADDR_IFACE, ADDR_PIN_ONE, ADDR_ADC_POWER,
    [ADDR_DC_CONFIG:ADDR_DC_READ_LO]};
  assign refused = !mapped || (page_q != 8'h00 && regAddr != ADDR_PAGE);
  assign pinSel = pinCfg_q[PIN_FUNC_MSB:PIN_FUNC_LSB] == PIN_FUNC_MODCLK;
  assign wordsOn = power_q[ADC_POWER_BIT] && !dcCfg_q[DC_ENABLE_BIT];
  assign rise = pinOneOut && !pinPrev_q;
  assign divWr = wr && regAddr inside {ADDR_DIV_FIRST, ADDR_DIV_SECOND,
    ADDR_PIN_ONE};
  assign period = {8'h00, ~|divF_q[6:0], divF_q[6:0]}
                * {8'h00, ~|divS_q[6:0], divS_q[6:0]};
  assign lowMask = iface_q[WL_MSB:WL_LSB] == 2'b00 ? 32'h0000_FFFF :
                   iface_q[WL_MSB:WL_LSB] == 2'b01 ? 32'h0000_0FFF :
                   iface_q[WL_MSB:WL_LSB] == 2'b10 ? 32'h0000_00FF :
                   32'h0000_0000;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      page_q   <= 8'h00;
      divF_q   <= DIV_RESET;
      divS_q   <= DIV_RESET;
      iface_q  <= REG_RESET;
      pinCfg_q <= REG_RESET;
      power_q  <= REG_RESET;
      dcCfg_q  <= REG_RESET;
    end
    else if (wr)
    begin
      case (regAddr)
        ADDR_PAGE:       page_q   <= regWrData;
        ADDR_DIV_FIRST:  divF_q   <= regWrData;
        ADDR_DIV_SECOND: divS_q   <= regWrData;
        ADDR_IFACE:      iface_q  <= regWrData;
        ADDR_PIN_ONE:    pinCfg_q <= regWrData;
        ADDR_ADC_POWER:  power_q  <= regWrData;
        ADDR_DC_CONFIG:  dcCfg_q  <= regWrData;
        default:         ;
      endcase
    end
  end
  always_ff @(posedge ref_clk)
  begin
    off_q     <= (rst || wordsOn) ? 3'd0 : off_q + {2'b00, off_q != 3'd7};
    gap_q     <= rise ? 16'h0001 : gap_q + 16'h0001;
    armed_q   <= !rst && !divWr && (armed_q || rise);
    pinPrev_q <= pinOneOut;
  end
  // ------------------------------------------
  // properties
  // ------------------------------------------
  sequence s_read;
    regRdEn && clkEn && refused;
  endsequence
  sequence s_rise;
    rise && armed_q;
  endsequence
  property p_rdHold;
    !$past(regRdEn) |-> $stable(regRdData);
  endproperty
  property p_rdRefuse;
    s_read |=> regRdData == 8'h00;
  endproperty
  property p_sameSlots;
    wordValid |-> leftWord == rightWord;
  endproperty
  property p_wlMask;
    wordValid |-> (leftWord & lowMask) == 32'h0000_0000;
  endproperty
  property p_pinDrive;
    pinSel && $past(pinSel) |-> !pinOneOeN;
  endproperty
  property p_pinIdle;
    !pinSel && !$past(pinSel) |-> pinOneOeN && !pinOneOut;
  endproperty
  property p_noWords;
    off_q >= 3'd4 |-> !wordValid;
  endproperty
  property p_modPeriod;
    s_rise |-> gap_q == period;
  endproperty
  a_rdHold: assert property (p_rdHold)
    else $error("read data moved without a read");
  a_rdRefuse: assert property (p_rdRefuse)
    else $error("refused read gave data");
  a_sameSlots: assert property (p_sameSlots)
    else $error("left and right words differ");
  a_wlMask: assert property (p_wlMask)
    else $error("word not rounded to length");
  a_pinDrive: assert property (p_pinDrive)
    else $error("pin one not driven");
  a_pinIdle: assert property (p_pinIdle)
    else $error("pin one driven while unselected");
  a_noWords: assert property (p_noWords)
    else $error("words while adc off or measuring");
  a_modPeriod: assert property (p_modPeriod)
    else $error("modulator clock period wrong");
endmodule // adc_backend_sva

bind adc_backend adc_backend_sva adc_backend_sva_i (.ref_clk, .rst, .clkEn,
  .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .pinOneOut,
  .pinOneOeN, .leftWord, .rightWord, .wordValid);

// ### dv/mic_model.sv
// Purpose : one-bit microphone clocked by the exported clock
// Assumes : the clock means something only while the pin is driven
// Notes   : HOLD_NS sets how late a new bit follows the clock fall
`timescale 1ns/1ps

module mic_model #(
  parameter int HOLD_NS = 30
) (
  input  wire logic modClk,
  input  wire logic clkOeN,
  input  wire logic level,
  output logic      bitOut
);
  initial bitOut = 1'b0;
  // new bit after the fall so it is steady at the rise
  always @(negedge modClk)
    if (!clkOeN)
      bitOut <= #HOLD_NS level;
  // unclocked microphone leaves no stable value on the line
  always #7
    if (clkOeN)
      bitOut = ~bitOut;
endmodule // mic_model

// ### dv/adc_backend_test.sv
// Purpose : self-checking bench of the adc back end
// Assumes : mic model answers on the exported modulator clock
// Notes   : dividers 5 and 2 give a 5 MHz modulator clock
`timescale 1ns/1ps

module adc_backend_test;
  import adc_backend_pkg::*;
  localparam logic [7:0]  OSR = 8'h08;
  localparam logic [23:0] ONE = 24'(1 << DC_FRAC_W);
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [6:0]  regAddr = 7'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        micMode = 1'b1;
  logic        analogModBit = 1'b0;
  logic        micLevel = 1'b0;
  logic        rdSeen = 1'b0;
  logic [7:0]  regRdData, rv;
  logic        serialDataIn, pinOneOut, pinOneOeN, wordValid;
  logic [ADC_WORD_W-1:0] leftWord, rightWord;
  logic [7:0]  rdQ[$];
  logic [31:0] wordQ[$];
  logic [6:0]  zeroRegs[$] = '{ADDR_PAGE, ADDR_IFACE, ADDR_PIN_ONE,
    ADDR_ADC_POWER, ADDR_DC_CONFIG, ADDR_DC_LATCH, ADDR_DC_READ_HI,
    ADDR_DC_READ_MD, ADDR_DC_READ_LO, 7'h70};
  int          errors = 0;
  int          n_tests = 0;
  int          nWords = 0;

  always #10 ref_clk = ~ref_clk;

  adc_backend adc_backend_i (.ref_clk, .rst, .clkEn, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .regRdData, .micMode, .analogModBit,
    .serialDataIn, .pinOneOut, .pinOneOeN, .leftWord, .rightWord,
    .wordValid);
  mic_model #(.HOLD_NS(30)) mic_model_i (.modClk(pinOneOut),
    .clkOeN(pinOneOeN), .level(micLevel), .bitOut(serialDataIn));

  // ------------------------------------------
  // compare tasks and output monitor
  // ------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk)
  begin
    if (rdSeen && rdQ.size() > 0)
      check8(regRdData, rdQ.pop_front());
    rdSeen <= regRdEn;
    if (wordValid === 1'b1)
    begin
      nWords <= nWords + 1;
      if (wordQ.size() > 0)
      begin
        checkWord(leftWord, wordQ[0]);
        checkWord(rightWord, wordQ.pop_front());
      end
    end
  end

  // ------------------------------------------
  // drivers
  // ------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b0;
  endtask
  task automatic waitWords(input int n);
    int t;
    t = nWords + n;
    for (int i = 0; i < 2000 && nWords < t; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (nWords < t)
    begin
      errors++;
      $display("MISMATCH %0t no sample words", $time);
    end
  endtask
  task automatic wordRun(input logic [1:0] wl, input logic mic,
                         input logic lvl);
    logic [31:0] e;
    e = 32'(OSR) << DC_FRAC_W;
    if (!lvl)
      e = -e;
    wr(ADDR_IFACE, {2'b00, wl, 4'h0});
    micMode = mic;
    micLevel = mic ? lvl : ~lvl;
    analogModBit = mic ? ~lvl : lvl;
    waitWords(3);
    wordQ.push_back(e);
    wordQ.push_back(e);
    waitWords(2);
    $display("test words length %0d mic %0d done", wl, mic);
  endtask
  task automatic dcRead(input logic [23:0] e);
    wr(ADDR_DC_LATCH, 8'h40);
    rd(ADDR_DC_READ_HI, e[23:16]);
    rd(ADDR_DC_READ_MD, e[15:8]);
    rd(ADDR_DC_READ_LO, e[7:0]);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #(40000 * 20);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    void'($urandom(84));
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rd(ADDR_DIV_FIRST, DIV_RESET);
    rd(ADDR_DIV_SECOND, DIV_RESET);
    rd(ADDR_OSR, OSR_RESET);
    foreach (zeroRegs[i])
      rd(zeroRegs[i], REG_RESET);
    wr(ADDR_DC_READ_HI, 8'hFF);
    rd(ADDR_DC_READ_HI, 8'h00);
    rv = 8'($urandom()) & 8'h3F;
    wr(ADDR_DC_CONFIG, rv);
    rd(ADDR_DC_CONFIG, rv);
    wr(ADDR_PAGE, 8'h01);
    rd(ADDR_DC_CONFIG, 8'h00);
    wr(ADDR_DC_CONFIG, 8'h00);
    wr(ADDR_PAGE, 8'h00);
    rd(ADDR_DC_CONFIG, rv);
    $display("test registers done");
    // host order: dividers, oversampling, pin, then adc power
    wr(ADDR_DIV_FIRST, 8'h85);
    wr(ADDR_DIV_SECOND, 8'h82);
    wr(ADDR_OSR, OSR);
    wr(ADDR_PIN_ONE, 8'h28);
    wr(ADDR_ADC_POWER, 8'h80);
    for (int w = 0; w < 4; w++)
      wordRun(2'(w), 1'b1, 1'($urandom()));
    wordRun(2'b10, 1'b0, 1'($urandom()));
    micMode = 1'b1;
    wr(ADDR_DC_CONFIG, 8'h82);
    micLevel = 1'b1;
    repeat (1500) @(posedge ref_clk);
    dcRead(ONE);
    micLevel = 1'b0;
    repeat (1500) @(posedge ref_clk);
    dcRead(ONE);
    wr(ADDR_DC_LATCH, 8'h00);
    dcRead(-ONE);
    wr(ADDR_DC_LATCH, 8'h00);
    $display("test averaging done");
    wr(ADDR_DC_CONFIG, 8'hA2);
    repeat (1500) @(posedge ref_clk);
    dcRead(-ONE);
    wr(ADDR_DC_LATCH, 8'h00);
    wr(ADDR_DC_CONFIG, 8'h00);
    $display("test iir done");
    // reset period below the length: averager never completes
    wr(ADDR_DC_LATCH, 8'h21);
    micLevel = 1'b1;
    wr(ADDR_DC_CONFIG, 8'h82);
    repeat (300) @(posedge ref_clk);
    dcRead(-ONE);
    wr(ADDR_DC_LATCH, 8'h00);
    wr(ADDR_DC_CONFIG, 8'h00);
    $display("test periodic reset done");
    print_verdict();
  end
endmodule // adc_backend_test
